// file: design/xpcs_defines.vh
// constants for the double-speed peripheral clock select block
`ifndef XPCS_DEFINES_VH
`define XPCS_DEFINES_VH

// ************************************************************
// register map
// ************************************************************
`define XPCS_ADDR_W          8
`define XPCS_CKCTL_ADDR      8'h8f
`define XPCS_CKCTL_RST_HI    7'h00
`define XPCS_CKCTL_WMASK     8'h7f
`define XPCS_STATUS_ADDR     8'h90
`define XPCS_UNMAPPED_RD     8'h00

// ************************************************************
// field positions
// ************************************************************
`define XPCS_BIT_DOUBLE      0
`define XPCS_BIT_TIMER_ZERO  1
`define XPCS_BIT_TIMER_ONE   2
`define XPCS_BIT_TIMER_TWO   3
`define XPCS_BIT_UART        4
`define XPCS_BIT_CNT_ARRAY   5
`define XPCS_BIT_WATCHDOG    6
`define XPCS_BIT_RESERVED    7

// ************************************************************
// oscillator periods per cycle, divider counter width and peripheral count
// ************************************************************
`define XPCS_FAST_PERIODS    6
`define XPCS_SLOW_PERIODS    12
`define XPCS_CNT_W           4
`define XPCS_NUM_PERIPH      6

`endif

// file: design/xpcs_tick_select.v
// glitch-free selection between a fast and a slow peripheral tick
`include "xpcs_defines.vh"

module xpcs_tick_select (
    // clock and reset
    input  wire clk_sys,
    input  wire reset,
    // tick sources and select
    input  wire tick_fast,
    input  wire tick_slow,
    input  wire use_slow,
    // selected enable
    output wire tick_out
);
    // select changes only on a slow tick, which is also a fast tick,
    // so no partial period or doubled tick appears on a switch
    reg sel_q;

    always @(posedge clk_sys) begin
        if (reset) begin
            sel_q <= 1'b1;
        end else if (tick_slow) begin
            sel_q <= use_slow;
        end
    end

    assign tick_out = sel_q ? tick_slow : tick_fast;
endmodule

// file: design/xpcs_clock_select.v
// double-speed cpu and peripheral clock select with control register
//
// Contract
// - select bit zero in double-speed mode: peripheral ticks every 6 periods
// - select bit one in double-speed mode: peripheral ticks every 12 periods
// - peripheral select bits ignored while double-speed bit is zero
// - bit 5 selects counter array rate
// - bit 4 selects uart rate, used only in uart modes 0 and 2
// - bits 3, 2, 1 select timer two, one, zero rates
// - double-speed bit zero: cpu and peripherals at 12 periods per cycle
// - double-speed bit one: cpu at 6 periods, peripheral bits effective
// - after power-up double-speed bit loads from configuration byte
// - reset clears bits 7 to 1, bit 0 takes configuration value
// - bit 6 selects watchdog rate; bit 7 reserved, kept zero
// - double-speed change takes effect on rising edge of osc divided by 2
`include "xpcs_defines.vh"

module xpcs_clock_select #(
    parameter CNT_W = `XPCS_CNT_W
) (
    // clock and reset (clk_sys is the oscillator)
    input  wire       clk_sys,
    input  wire       reset,
    // configuration byte double-speed bit, static after power-up
    input  wire       hardware_config_byte,
    // uart mode: high when uart runs in mode 0 or 2
    input  wire       uart_mode_sync,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // cpu and peripheral clock enables
    output wire       cpu_tick,
    output wire       counter_array_tick,
    output wire       uart_tick,
    output wire       timer_two_tick,
    output wire       timer_one_tick,
    output wire       timer_zero_tick,
    output wire       watchdog_tick,
    // effective mode
    output wire       double_speed_mode
);
    // ************************************************************
    // control register
    // ************************************************************
    reg  [7:0]  clock_speed_control_q;
    reg         cfg_s1_q;
    reg         cfg_s2_q;
    reg         cfg_s3_q;
    reg         cfg_load_q;
    reg         osc_half_q;
    reg         double_eff_q;
    wire        wr_ctl;

    assign wr_ctl = reg_wr && (reg_addr == `XPCS_CKCTL_ADDR);

    // the configuration pin is synchronised; it is static, so the value
    // seen once the second and third stages agree is loaded once.
    // the stages keep sampling through reset: clearing them would let
    // two cleared stages agree and load zero before the pin arrives
    always @(posedge clk_sys) begin
        cfg_s1_q <= hardware_config_byte;
        cfg_s2_q <= cfg_s1_q;
        cfg_s3_q <= cfg_s2_q;
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            clock_speed_control_q <= 8'h00;
            cfg_load_q            <= 1'b1;
        end else if (cfg_load_q) begin
            if (cfg_s2_q == cfg_s3_q) begin
                // configuration value into bit 0, others stay zero
                clock_speed_control_q <= {`XPCS_CKCTL_RST_HI, cfg_s3_q};
                cfg_load_q            <= 1'b0;
            end
        end else if (wr_ctl) begin
            // bit 7 is reserved and cannot be set
            clock_speed_control_q <= reg_wdata & `XPCS_CKCTL_WMASK;
        end
    end

    // ************************************************************
    // double-speed switch, on the oscillator divided by two
    // ************************************************************
    always @(posedge clk_sys) begin
        if (reset) begin
            osc_half_q   <= 1'b0;
            double_eff_q <= 1'b0;
        end else begin
            osc_half_q <= ~osc_half_q;
            // rising edge of the half-rate clock: it goes 0 to 1 now
            if (!osc_half_q) begin
                double_eff_q <=
                    clock_speed_control_q[`XPCS_BIT_DOUBLE];
            end
        end
    end

    assign double_speed_mode = double_eff_q;

    // ************************************************************
    // tick generators: 6 and 12 oscillator periods
    // ************************************************************
    reg  [CNT_W-1:0] div_cnt_q;
    wire             tick6;
    wire             tick12;

    always @(posedge clk_sys) begin
        if (reset) begin
            div_cnt_q <= {CNT_W{1'b0}};
        end else if (div_cnt_q == `XPCS_SLOW_PERIODS - 1) begin
            div_cnt_q <= {CNT_W{1'b0}};
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    // every 12th is also a 6th, so a switch lands on a common boundary
    assign tick12 = (div_cnt_q == {CNT_W{1'b0}});
    assign tick6  = tick12
                 || (div_cnt_q == `XPCS_FAST_PERIODS);

    // cpu: 6 periods in double-speed mode, else 12
    assign cpu_tick = double_eff_q ? tick6 : tick12;

    // ************************************************************
    // per-peripheral selection
    // ************************************************************
    wire [`XPCS_NUM_PERIPH-1:0] slow_sel;
    wire [`XPCS_NUM_PERIPH-1:0] periph_tick;
    wire [`XPCS_NUM_PERIPH-1:0] raw_sel;

    // peripheral order: t0, t1, t2, uart, counter array, watchdog
    assign raw_sel = clock_speed_control_q[`XPCS_BIT_WATCHDOG:
                                           `XPCS_BIT_TIMER_ZERO];

    genvar gi;
    generate
        for (gi = 0; gi < `XPCS_NUM_PERIPH; gi = gi + 1) begin : g_periph
            // standard mode forces slow; double-speed: 0 fast, 1 slow
            assign slow_sel[gi] = ~double_eff_q | raw_sel[gi];

            xpcs_tick_select u_sel (
                .clk_sys   (clk_sys),
                .reset     (reset),
                .tick_fast (tick6),
                .tick_slow (tick12),
                .use_slow  (slow_sel[gi]),
                .tick_out  (periph_tick[gi])
            );
        end
    endgenerate

    assign timer_zero_tick    = periph_tick[0];
    assign timer_one_tick     = periph_tick[1];
    assign timer_two_tick     = periph_tick[2];
    // outside modes 0 and 2 the uart follows the standard rate
    assign uart_tick          = uart_mode_sync ? periph_tick[3] : tick12;
    assign counter_array_tick = periph_tick[4];
    assign watchdog_tick      = periph_tick[5];

    // ************************************************************
    // read port
    // ************************************************************
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= `XPCS_UNMAPPED_RD;
        end else if (reg_rd) begin
            case (reg_addr)
                `XPCS_CKCTL_ADDR:  reg_rdata <= clock_speed_control_q;
                `XPCS_STATUS_ADDR: reg_rdata <= {7'h00, double_eff_q};
                default:           reg_rdata <= `XPCS_UNMAPPED_RD;
            endcase
        end else begin
            reg_rdata <= `XPCS_UNMAPPED_RD;
        end
    end
endmodule

// file: bench/xpcs_checker.sv
// assertion checker for the double-speed clock select block
// ************************************************************
// port relations
// ************************************************************
module xpcs_checker (
    // clock and reset
    input logic       clk_sys,
    input logic       reset,
    // mode inputs
    input logic       hardware_config_byte,
    input logic       uart_mode_sync,
    // register port
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    // clock enables
    input logic       cpu_tick,
    input logic       counter_array_tick,
    input logic       uart_tick,
    input logic       timer_two_tick,
    input logic       timer_one_tick,
    input logic       timer_zero_tick,
    input logic       watchdog_tick,
    input logic       double_speed_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [7:0] shadow_q;
    logic [7:0] rd_exp_q;
    logic [3:0] settle_q;
    logic       hit;
    logic [5:0] pt;
    logic [5:0] slow;
    assign hit = reg_wr && reg_addr == 8'h8f;
    assign pt = {watchdog_tick, counter_array_tick, uart_tick,
                 timer_two_tick, timer_one_tick, timer_zero_tick};
    // uart outside modes 0 and 2 always runs slow
    assign slow = shadow_q[6:1] | {2'b00, !uart_mode_sync, 3'b000};
    // selects only move at a slow tick, so wait a full slow period
    always @(posedge clk_sys) begin
        rd_exp_q <= shadow_q;
        if (reset || hit || $changed(double_speed_mode)) begin
            settle_q <= 4'h0;
        end else if ($changed(uart_mode_sync)) begin
            settle_q <= 4'h0;
        end else if (settle_q != 4'hf) begin
            settle_q <= settle_q + 4'h1;
        end
        if (reset) begin
            shadow_q <= 8'h00;
        end else if (hit) begin
            shadow_q <= reg_wdata & 8'h7f;
        end
    end
    a_cpu_fast_rate: assert property (cpu_tick && double_speed_mode ##1
        double_speed_mode [*6] |-> cpu_tick) else $error("fast cpu rate");
    a_cpu_slow_rate: assert property (cpu_tick && !double_speed_mode ##1
        !double_speed_mode [*6] |-> !cpu_tick)
        else $error("standard cpu rate");
    a_plain_ignore_sel: assert property (settle_q >= 4'he &&
        !double_speed_mode |-> pt == {6{cpu_tick}})
        else $error("select bits not ignored");
    a_fast_sel_rate: assert property (settle_q >= 4'he &&
        double_speed_mode |-> ((pt ^ {6{cpu_tick}}) & ~slow) == 6'h00)
        else $error("fast peripheral rate");
    // no write may move the selects while a slow period is being timed
    a_slow_sel_gap: assert property (settle_q >= 4'he && !hit &&
        double_speed_mode && (pt & slow) != 6'h00 ##1
        (!hit && double_speed_mode) [*6] |-> (pt & slow) == 6'h00)
        else $error("slow peripheral early tick");
    a_slow_sel_period: assert property (settle_q >= 4'he && !hit &&
        double_speed_mode && (pt & slow) != 6'h00 ##1
        (!hit && double_speed_mode) [*8] ##1
        (!hit && double_speed_mode) [*4] |-> (pt & slow) == slow)
        else $error("slow peripheral period");
    a_ctrl_readback: assert property (reg_rd && reg_addr == 8'h8f
        |=> reg_rdata[7:1] == rd_exp_q[7:1]) else $error("readback");
    a_mode_switch_time: assert property (hit ##1 !reg_wr [*3]
        |-> double_speed_mode == shadow_q[0]) else $error("mode switch");
    a_config_load: assert property ($fell(reset) ##1 !reg_wr [*8]
        |-> double_speed_mode == hardware_config_byte)
        else $error("config load");
endmodule

bind xpcs_clock_select xpcs_checker xpcs_checker_inst (
    .clk_sys, .reset, .hardware_config_byte, .uart_mode_sync, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_tick,
    .counter_array_tick, .uart_tick, .timer_two_tick, .timer_one_tick,
    .timer_zero_tick, .watchdog_tick, .double_speed_mode
);

// file: bench/xpcs_clock_select_test.sv
// self-checking testbench for the double-speed clock select block
// ************************************************************
// bench
// ************************************************************
module xpcs_clock_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       reset = 1'b1;
    logic       hardware_config_byte = 1'b0;
    logic       uart_mode_sync = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    wire  [7:0] reg_rdata;
    wire  [6:0] tk;
    int         num_errors = 0;
    int         n_checks = 0;
    always #4 clk_sys = ~clk_sys;
    xpcs_clock_select xpcs_clock_select_inst (
        .clk_sys, .reset, .hardware_config_byte, .uart_mode_sync, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_tick(tk[0]),
        .timer_zero_tick(tk[1]), .timer_one_tick(tk[2]),
        .timer_two_tick(tk[3]), .uart_tick(tk[4]),
        .counter_array_tick(tk[5]), .watchdog_tick(tk[6]),
        .double_speed_mode()
    );
    task automatic report_and_stop;
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // writes wait long enough for the select to reach the ticks
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        repeat (16) @(posedge clk_sys);
    endtask
    task automatic rd_reg(input logic [7:0] a, m, exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata & m, exp);
    endtask
    task automatic wait_tick(input int i, output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (tk[i] !== 1'b1 && n < 40);
        if (tk[i] !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic gap(input int i, input int exp);
        int n;
        wait_tick(i, n);
        wait_tick(i, n);
        chk(8'(n), 8'(exp));
    endtask
    task automatic do_reset(input logic c);
        @(posedge clk_sys);
        reset <= 1'b1;
        hardware_config_byte <= c;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (12) @(posedge clk_sys);
    endtask
    initial begin
        do_reset(1'b0);
        rd_reg(8'h8f, 8'hff, 8'h00);
        rd_reg(8'h90, 8'h01, 8'h00);
        rd_reg(8'h55, 8'hff, 8'h00);
        for (int i = 0; i < 7; i++) gap(i, 12);
        wr_reg(8'h8f, 8'hff);
        rd_reg(8'h8f, 8'hff, 8'h7f);
        gap(0, 6);
        for (int i = 1; i < 7; i++) gap(i, 12);
        for (int k = 1; k < 7; k++) begin
            wr_reg(8'h8f, 8'(1 | (1 << k)));
            for (int i = 1; i < 7; i++) gap(i, (i == k) ? 12 : 6);
        end
        @(posedge clk_sys);
        uart_mode_sync <= 1'b0;
        wr_reg(8'h8f, 8'h01);
        gap(4, 12);
        gap(1, 6);
        wr_reg(8'h8f, 8'h7e);
        for (int i = 0; i < 7; i++) gap(i, 12);
        do_reset(1'b1);
        rd_reg(8'h8f, 8'hff, 8'h01);
        rd_reg(8'h90, 8'h01, 8'h01);
        gap(0, 6);
        report_and_stop();
    end
endmodule
